// *** rtl/cmpvr_top.sv ***
// comparator and ladder reference control registers with event interrupt
// assumes wishbone classic master on clk; analog result arrives asynchronously
`default_nettype none
// Overview of operation
// - comparator enable bit, other bits untouched
// - pin enable drives result onto pin
// - invert bit inverts presented result
// - inversion also feeds interrupt edge detector
// - status bit reads present result, resets zero
// - edge field: none, rise, fall, both
// - positive select: ladder or external pin
// - negative select: pin, two inputs, bandgap
// - reference enable bit, other bits untouched
// - bypass select takes high reference pin
// - bandgap field selects level, default 0.6
// - ladder pin enable connects reference output
// - range select: low or offset range
// - source select: reference pins or supply
// - four-bit tap sets ladder step
// - unimplemented bits read zero, ignore writes
module cmpvr_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic comparator_raw,
    output logic comparator_enable,
    output logic result_pin,
    output logic result_pin_oe,
    output logic positive_input_select,
    output logic [1:0] negative_input_select,
    output logic reference_enable,
    output logic ladder_bypass_select,
    output logic [1:0] bandgap_source_select,
    output logic ladder_pin_enable,
    output logic ladder_range_select,
    output logic ladder_source_select,
    output logic [3:0] ladder_tap_value,
    output logic irq
);
    typedef struct packed {
        logic [31:0] cmp_ctrl;
        logic [31:0] ref_ctrl;
        logic status;
        logic mask;
        logic sync_a;
        logic sync_b;
        logic prev_eff;
        logic eff;
        logic ack;
        logic [31:0] rdata;
        logic irq;
        logic pin;
        logic pin_oe;
    } cmpvr_state_type;

    cmpvr_state_type state;
    cmpvr_state_type next_state;

    logic [31:0] byte_mask;
    logic access;
    logic write_now;
    logic rise_seen;
    logic fall_seen;
    logic event_hit;
    logic [1:0] edge_sel;
    logic cmp_write;
    logic ref_write;
    logic status_write;
    logic mask_write;
    logic cmp_read;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            byte_mask[i*8 +: 8] = {8{wb_sel_i[i]}};
        end
    end

    // one registered ack per request, a cycle after it, dropped the cycle after
    assign access = wb_cyc_i && wb_stb_i && !state.ack;
    assign write_now = access && wb_we_i;
    assign edge_sel = state.cmp_ctrl[cmpvr_pkg::event_edge_select_pos +: 2];
    assign rise_seen = state.eff && !state.prev_eff;
    assign fall_seen = !state.eff && state.prev_eff;
    assign cmp_write = write_now && wb_adr_i == cmpvr_pkg::comparator_control_offset;
    assign ref_write = write_now && wb_adr_i == cmpvr_pkg::reference_ladder_control_offset;
    assign status_write = write_now && wb_adr_i == cmpvr_pkg::event_status_offset;
    assign mask_write = write_now && wb_adr_i == cmpvr_pkg::event_mask_offset;
    assign cmp_read = access && !wb_we_i && wb_adr_i == cmpvr_pkg::comparator_control_offset;

    always_comb begin
        unique case (edge_sel)
            cmpvr_pkg::edge_rise: event_hit = rise_seen;
            cmpvr_pkg::edge_fall: event_hit = fall_seen;
            cmpvr_pkg::edge_both: event_hit = rise_seen || fall_seen;
            default: event_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        // second stage only is read, first feeds nothing else
        next_state.sync_a = comparator_raw;
        next_state.sync_b = state.sync_a;
        // disabled comparator presents a low result, or a high one with the invert bit set
        next_state.eff = (state.sync_b && state.cmp_ctrl[cmpvr_pkg::cmp_enable_pos])
            ^ state.cmp_ctrl[cmpvr_pkg::result_invert_pos];
        next_state.prev_eff = state.eff;
        next_state.ack = access;
        if (write_now && wb_adr_i == cmpvr_pkg::comparator_control_offset) begin
            // masked write changes only writable bits in the selected byte lanes
            next_state.cmp_ctrl = (state.cmp_ctrl & ~(byte_mask
                & cmpvr_pkg::comparator_writable_mask))
                | (wb_dat_i & byte_mask & cmpvr_pkg::comparator_writable_mask);
        end
        if (write_now && wb_adr_i == cmpvr_pkg::reference_ladder_control_offset) begin
            next_state.ref_ctrl = (state.ref_ctrl & ~(byte_mask
                & cmpvr_pkg::ladder_writable_mask))
                | (wb_dat_i & byte_mask & cmpvr_pkg::ladder_writable_mask);
        end
        if (write_now && wb_adr_i == cmpvr_pkg::event_mask_offset && wb_sel_i[0]) begin
            next_state.mask = wb_dat_i[cmpvr_pkg::event_status_pos];
        end
        // set wins over a simultaneous write-one clear
        if (write_now && wb_adr_i == cmpvr_pkg::event_status_offset && wb_sel_i[0]
                && wb_dat_i[cmpvr_pkg::event_status_pos]) begin
            next_state.status = 1'b0;
        end
        if (event_hit) begin
            next_state.status = 1'b1;
        end
        next_state.rdata = 32'h0000_0000;
        if (access && !wb_we_i) begin
            unique case (wb_adr_i)
                cmpvr_pkg::comparator_control_offset: begin
                    next_state.rdata = state.cmp_ctrl;
                    next_state.rdata[cmpvr_pkg::result_status_pos] =
                        state.sync_b && state.cmp_ctrl[cmpvr_pkg::cmp_enable_pos];
                end
                cmpvr_pkg::reference_ladder_control_offset: next_state.rdata = state.ref_ctrl;
                cmpvr_pkg::event_status_offset: next_state.rdata = {31'h0, state.status};
                cmpvr_pkg::event_mask_offset: next_state.rdata = {31'h0, state.mask};
                default: next_state.rdata = 32'h0000_0000;
            endcase
        end
        next_state.irq = next_state.status && next_state.mask;
        next_state.pin = next_state.eff;
        next_state.pin_oe = next_state.cmp_ctrl[cmpvr_pkg::result_pin_enable_pos];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '{cmp_ctrl: cmpvr_pkg::comparator_reset,
                ref_ctrl: cmpvr_pkg::ladder_reset, default: '0};
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign wb_dat_o = state.rdata;
    assign wb_ack_o = state.ack;
    assign irq = state.irq;
    assign result_pin = state.pin;
    assign result_pin_oe = state.pin_oe;
    assign comparator_enable = state.cmp_ctrl[cmpvr_pkg::cmp_enable_pos];
    assign positive_input_select = state.cmp_ctrl[cmpvr_pkg::positive_input_select_pos];
    assign negative_input_select =
        state.cmp_ctrl[cmpvr_pkg::negative_input_select_pos +: 2];
    assign reference_enable = state.ref_ctrl[cmpvr_pkg::ref_enable_pos];
    assign ladder_bypass_select = state.ref_ctrl[cmpvr_pkg::ladder_bypass_select_pos];
    assign bandgap_source_select =
        state.ref_ctrl[cmpvr_pkg::bandgap_source_select_pos +: 2];
    assign ladder_pin_enable = state.ref_ctrl[cmpvr_pkg::ladder_pin_enable_pos];
    assign ladder_range_select = state.ref_ctrl[cmpvr_pkg::ladder_range_select_pos];
    assign ladder_source_select = state.ref_ctrl[cmpvr_pkg::ladder_source_select_pos];
    assign ladder_tap_value = state.ref_ctrl[cmpvr_pkg::ladder_tap_value_pos +: 4];

    // bus handshake: one registered ack per request, data only with a read
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (reset)
        clk_en && wb_ack_o
        |=> !wb_ack_o)
        else $error("ack held too long");

    a_ack_after_req: assert property (@(posedge clk) disable iff (reset)
        clk_en && access
        |=> wb_ack_o)
        else $error("request not acknowledged");

    a_ack_needs_req: assert property (@(posedge clk) disable iff (reset)
        clk_en && !access
        |=> !wb_ack_o)
        else $error("ack without request");

    a_read_zero_idle: assert property (@(posedge clk) disable iff (reset)
        clk_en && !(access && !wb_we_i)
        |=> wb_dat_o == 32'h0000_0000)
        else $error("read data outside a read");

    a_freeze_all: assert property (@(posedge clk) disable iff (reset)
        !clk_en
        |=> $stable(state))
        else $error("state moved while frozen");

    a_status_after_reset: assert property (@(posedge clk) disable iff (reset)
        $past(reset)
        |-> wb_dat_o == 32'h0000_0000 && !irq && !state.status)
        else $error("outputs not quiet after reset");

    // control fields land only through their own byte lane
    a_enable_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && cmp_write && wb_sel_i[1]
        |=> comparator_enable == $past(wb_dat_i[cmpvr_pkg::cmp_enable_pos]))
        else $error("comparator enable not written");

    a_enable_lane_kept: assert property (@(posedge clk) disable iff (reset)
        clk_en && cmp_write && !wb_sel_i[1]
        |=> $stable(comparator_enable))
        else $error("comparator enable disturbed");

    a_cmp_hold: assert property (@(posedge clk) disable iff (reset)
        clk_en && !cmp_write
        |=> $stable(state.cmp_ctrl))
        else $error("comparator control moved");

    a_pin_follows: assert property (@(posedge clk) disable iff (reset)
        clk_en && cmp_write && wb_sel_i[1]
        |=> result_pin_oe == $past(wb_dat_i[cmpvr_pkg::result_pin_enable_pos]))
        else $error("pin enable mismatch");

    a_pin_value: assert property (@(posedge clk) disable iff (reset)
        1'b1
        |-> result_pin == state.eff)
        else $error("pin not presented result");

    a_invert_eff: assert property (@(posedge clk) disable iff (reset)
        clk_en && $past(clk_en) && !$past(reset) |-> state.eff == $past((state.sync_b
            && comparator_enable) ^ state.cmp_ctrl[cmpvr_pkg::result_invert_pos]))
        else $error("inverted result wrong");

    a_no_invert_pass: assert property (@(posedge clk) disable iff (reset)
        clk_en && !state.cmp_ctrl[cmpvr_pkg::result_invert_pos] && comparator_enable && !cmp_write
        |=> state.eff == $past(state.sync_b))
        else $error("result not passed through");

    a_edge_input_inverted: assert property (@(posedge clk) disable iff (reset)
        clk_en && state.cmp_ctrl[cmpvr_pkg::result_invert_pos] && comparator_enable && !cmp_write
        |=> state.eff == !$past(state.sync_b))
        else $error("edge detector not inverted");

    a_status_bit_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && cmp_read
        |=> wb_dat_o[cmpvr_pkg::result_status_pos] == $past(state.sync_b && comparator_enable))
        else $error("result status wrong");

    a_status_off_zero: assert property (@(posedge clk) disable iff (reset)
        clk_en && cmp_read && !comparator_enable
        |=> !wb_dat_o[cmpvr_pkg::result_status_pos])
        else $error("status set while disabled");

    // event edges and the sticky status behind the interrupt line
    a_rise_event: assert property (@(posedge clk) disable iff (reset)
        clk_en && edge_sel == cmpvr_pkg::edge_rise && rise_seen
        |=> state.status)
        else $error("rise event lost");

    a_fall_event: assert property (@(posedge clk) disable iff (reset)
        clk_en && edge_sel == cmpvr_pkg::edge_fall && fall_seen
        |=> state.status)
        else $error("fall event lost");

    a_both_event: assert property (@(posedge clk) disable iff (reset)
        clk_en && edge_sel == cmpvr_pkg::edge_both && (rise_seen || fall_seen)
        |=> state.status)
        else $error("either-edge event lost");

    a_none_quiet: assert property (@(posedge clk) disable iff (reset)
        clk_en && edge_sel == cmpvr_pkg::edge_none && !state.status
            && !write_now |=> !state.status)
        else $error("event with edges disabled");

    a_rise_only: assert property (@(posedge clk) disable iff (reset)
        clk_en && edge_sel == cmpvr_pkg::edge_rise && !rise_seen && !state.status
        |=> !state.status)
        else $error("event without rising edge");

    a_fall_only: assert property (@(posedge clk) disable iff (reset)
        clk_en && edge_sel == cmpvr_pkg::edge_fall && !fall_seen && !state.status
        |=> !state.status)
        else $error("event without falling edge");

    a_event_irq: assert property (@(posedge clk) disable iff (reset)
        clk_en && event_hit && state.mask && !mask_write
        |=> irq)
        else $error("unmasked event without irq");

    a_irq_level: assert property (@(posedge clk) disable iff (reset)
        1'b1
        |-> irq == (state.status && state.mask))
        else $error("irq not status and mask");

    a_masked_quiet: assert property (@(posedge clk) disable iff (reset)
        clk_en && !state.mask && !mask_write
        |=> !irq)
        else $error("masked event raised irq");

    a_status_clear: assert property (@(posedge clk) disable iff (reset)
        clk_en && status_write && wb_sel_i[0] && wb_dat_i[cmpvr_pkg::event_status_pos] && !event_hit
        |=> !state.status)
        else $error("status not cleared");

    a_status_sticky: assert property (@(posedge clk) disable iff (reset)
        clk_en && state.status && !status_write
        |=> state.status)
        else $error("status lost without clear");

    // input routing and ladder fields
    a_posin_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && cmp_write && wb_sel_i[0]
        |=> positive_input_select == $past(wb_dat_i[cmpvr_pkg::positive_input_select_pos]))
        else $error("positive select not written");

    a_negin_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && cmp_write && wb_sel_i[0]
        |=> negative_input_select == $past(wb_dat_i[cmpvr_pkg::negative_input_select_pos +: 2]))
        else $error("negative select not written");

    a_ref_enable_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && ref_write && wb_sel_i[1]
        |=> reference_enable == $past(wb_dat_i[cmpvr_pkg::ref_enable_pos]))
        else $error("reference enable not written");

    a_ref_hold: assert property (@(posedge clk) disable iff (reset)
        clk_en && !ref_write
        |=> $stable(state.ref_ctrl))
        else $error("ladder control moved");

    a_bypass_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && ref_write && wb_sel_i[1]
        |=> ladder_bypass_select == $past(wb_dat_i[cmpvr_pkg::ladder_bypass_select_pos]))
        else $error("bypass select not written");

    a_bandgap_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && ref_write && wb_sel_i[1]
        |=> bandgap_source_select == $past(wb_dat_i[cmpvr_pkg::bandgap_source_select_pos +: 2]))
        else $error("bandgap select not written");

    a_ladder_pin_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && ref_write && wb_sel_i[0]
        |=> ladder_pin_enable == $past(wb_dat_i[cmpvr_pkg::ladder_pin_enable_pos]))
        else $error("ladder pin enable not written");

    a_range_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && ref_write && wb_sel_i[0]
        |=> ladder_range_select == $past(wb_dat_i[cmpvr_pkg::ladder_range_select_pos]))
        else $error("range select not written");

    a_source_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && ref_write && wb_sel_i[0]
        |=> ladder_source_select == $past(wb_dat_i[cmpvr_pkg::ladder_source_select_pos]))
        else $error("source select not written");

    a_tap_write: assert property (@(posedge clk) disable iff (reset)
        clk_en && ref_write && wb_sel_i[0]
        |=> ladder_tap_value == $past(wb_dat_i[cmpvr_pkg::ladder_tap_value_pos +: 4]))
        else $error("tap value not written");

    // reserved space reads back empty
    a_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
        (state.cmp_ctrl & ~cmpvr_pkg::comparator_writable_mask) == 32'h0
            && (state.ref_ctrl & ~cmpvr_pkg::ladder_writable_mask) == 32'h0)
        else $error("unimplemented bit set");

    a_upper_zero: assert property (@(posedge clk) disable iff (reset)
        wb_ack_o
        |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper half not zero");

    a_unmapped_read: assert property (@(posedge clk) disable iff (reset)
        clk_en && access && !wb_we_i && wb_adr_i[1:0] != 2'h0
        |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped address read nonzero");

    // two flops before anything looks at the analog result
    a_sync_first: assert property (@(posedge clk) disable iff (reset)
        $past(clk_en) && !$past(reset)
        |-> state.sync_a == $past(comparator_raw))
        else $error("first sync stage wrong");

    a_sync_delay: assert property (@(posedge clk) disable iff (reset)
        $past(clk_en) && $past(clk_en, 2) && !$past(reset) && !$past(reset, 2)
        |-> state.sync_b == $past(comparator_raw, 2))
        else $error("synchroniser depth wrong");
endmodule : cmpvr_top
`default_nettype wire

// *** rtl/cmpvr_pkg.sv ***
// package for the comparator and ladder reference control block
// assumes a 32-bit classic wishbone slave with word addressing by byte address
`default_nettype none
package cmpvr_pkg;
    // register byte offsets
    localparam logic [3:0] comparator_control_offset = 4'h0;
    localparam logic [3:0] reference_ladder_control_offset = 4'h4;
    localparam logic [3:0] event_status_offset = 4'h8;
    localparam logic [3:0] event_mask_offset = 4'hc;
    // comparator control fields
    localparam int cmp_enable_pos = 15;
    localparam int result_pin_enable_pos = 14;
    localparam int result_invert_pos = 13;
    localparam int result_status_pos = 8;
    localparam int event_edge_select_pos = 6;
    localparam int positive_input_select_pos = 4;
    localparam int negative_input_select_pos = 0;
    localparam logic [31:0] comparator_writable_mask = 32'h0000_e0d3;
    localparam logic [31:0] comparator_reset = 32'h0000_00c3;
    // reference ladder control fields
    localparam int ref_enable_pos = 15;
    localparam int ladder_bypass_select_pos = 10;
    localparam int bandgap_source_select_pos = 8;
    localparam int ladder_pin_enable_pos = 6;
    localparam int ladder_range_select_pos = 5;
    localparam int ladder_source_select_pos = 4;
    localparam int ladder_tap_value_pos = 0;
    localparam logic [31:0] ladder_writable_mask = 32'h0000_877f;
    localparam logic [31:0] ladder_reset = 32'h0000_0100;
    // event edge encodings
    localparam logic [1:0] edge_none = 2'h0;
    localparam logic [1:0] edge_rise = 2'h1;
    localparam logic [1:0] edge_fall = 2'h2;
    localparam logic [1:0] edge_both = 2'h3;
    // status bits
    localparam int event_status_pos = 0;
endpackage : cmpvr_pkg
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the comparator and ladder reference control block
// assumes cmpvr_pkg is compiled first; the bench ties clk_en and wb_sel_i high and drives the other inputs of cmpvr_top
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, raw = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rd, dat_o, v, c;
    logic [31:0] seed = 32'h3b03;
    logic ack, cen, opin, oe, psel, ren, byp, lpe, lrs, lss, irq, dir, inv, e;
    logic [1:0] nsel, bgs, sel;
    logic [3:0] tap;
    int err_total = 0, samples_checked = 0, cycles = 0;
    always #5 clk = ~clk;
    cmpvr_top cmpvr_top_inst (.clk(clk), .reset(reset), .clk_en(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .comparator_raw(raw), .comparator_enable(cen),
        .result_pin(opin), .result_pin_oe(oe), .positive_input_select(psel),
        .negative_input_select(nsel), .reference_enable(ren), .ladder_bypass_select(byp),
        .bandgap_source_select(bgs), .ladder_pin_enable(lpe), .ladder_range_select(lrs),
        .ladder_source_select(lss), .ladder_tap_value(tap), .irq(irq));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // classic cycle: request held until ack is sampled, data taken at that edge
    // every access leaves an idle cycle, so none follows a disable at once
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus
    // a hang anywhere ends here as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, 4'h0, 32'h0);
        check(rd, cmpvr_pkg::comparator_reset);
        bus(1'b0, 4'h4, 32'h0);
        check(rd, cmpvr_pkg::ladder_reset);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = seed;
            bus(1'b1, 4'h0, v);
            bus(1'b0, 4'h0, 32'h0);
            c = v & cmpvr_pkg::comparator_writable_mask;
            check(rd, c);
            check({cen, psel, nsel}, {c[15], c[4], c[1:0]});
            seed = xs(seed);
            v = seed;
            bus(1'b1, 4'h4, v);
            bus(1'b0, 4'h4, 32'h0);
            c = v & cmpvr_pkg::ladder_writable_mask;
            check(rd, c);
            check({ren, byp, bgs, lpe, lrs, lss, tap}, {c[15], c[10:8], c[6:0]});
        end
        bus(1'b1, 4'hc, 32'h1);
        // every edge code, with and without inversion, for both raw directions
        for (int k = 0; k < 16; k++) begin
            inv = k[0];
            sel = k[2:1];
            dir = k[3];
            c = 32'h0000_c000 | {18'h0, inv, 13'h0} | {24'h0, sel, 6'h0};
            raw <= ~dir;
            bus(1'b1, 4'h0, c);
            repeat (8) @(posedge clk);
            bus(1'b1, 4'h8, 32'h1);
            raw <= dir;
            repeat (8) @(posedge clk);
            check({oe, opin}, {1'b1, dir ^ inv});
            bus(1'b0, 4'h0, 32'h0);
            check(rd, c | {23'h0, dir, 8'h0});
            e = (sel == 2'h3) || (sel == 2'h1 && (dir ^ inv)) || (sel == 2'h2 && !(dir ^ inv));
            bus(1'b0, 4'h8, 32'h0);
            check(rd, {31'h0, e});
            check(irq, e);
        end
        // last pass leaves the event pending; masking must drop the line
        bus(1'b1, 4'hc, 32'h0);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        bus(1'b1, 4'h8, 32'h1);
        bus(1'b0, 4'h8, 32'h0);
        check(rd, 32'h0);
        // switching off: pin released, status reads low
        bus(1'b1, 4'h0, 32'h0);
        check({oe, cen}, 2'h0);
        bus(1'b0, 4'h0, 32'h0);
        check(rd, 32'h0);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
